// ===== design/flash_sp_pkg.sv
package flash_sp_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register placement in sector one
	localparam logic [7:0] SECTOR_ONE = 8'h01;
	localparam logic [7:0] OFF_CTRL = 8'h43;
	localparam logic [7:0] OFF_RESET_CMD = 8'h44;
	localparam logic [7:0] OFF_BUF_CLEAR = 8'h45;
	localparam logic [7:0] OFF_ADDR_LOW = 8'h46;
	localparam logic [7:0] OFF_ADDR_HIGH = 8'h47;
	localparam logic [7:0] OFF_DATA_FIRST = 8'h48;
	localparam logic [7:0] OFF_DATA_LAST = 8'h4F;

	////////////////////////////////////////////////////////////////////////
	// Control register fields
	localparam int BIT_WEN = 7;
	localparam int MODE_HI = 6;
	localparam int MODE_LO = 4;
	localparam int BIT_UNLOCK = 3;
	localparam int BIT_WSTART = 2;
	localparam int BIT_RPERMIT = 1;
	localparam int BIT_RSTART = 0;
	localparam int BIT_BCLR = 0;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [6:0] BCLR_PAD = 7'h00;

	typedef logic [2:0] mode_t;
	localparam mode_t MODE_PROG = 3'h0;
	localparam mode_t MODE_ERASE = 3'h1;
	localparam mode_t MODE_READ = 3'h3;
	localparam mode_t MODE_UNLOCK = 3'h6;

	localparam logic [7:0] RESET_CMD = 8'h55;

	////////////////////////////////////////////////////////////////////////
	// Flash geometry and word address
	localparam int PAGE_WORDS = 64;
	localparam int IDX_W = 6;
	localparam int ADDR_W = 15;
	localparam logic [IDX_W-1:0] LAST_IDX = 6'h3F;
	localparam logic [IDX_W-1:0] IDX_ZERO = 6'h00;
	localparam logic [ADDR_W-1:0] MASK_LARGE = 15'h7FFF;
	localparam logic [ADDR_W-1:0] MASK_SMALL = 15'h3FFF;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 15'h0001;

	typedef enum logic [1:0] {FL_NONE, FL_PROG, FL_ERASE, FL_READ} flash_cmd_e;

	////////////////////////////////////////////////////////////////////////
	// Unlock pattern and timeout
	localparam int UNLOCK_LEN = 6;
	localparam logic [47:0] UNLOCK_PATTERN = 48'h00040D09C340;
	localparam logic [2:0] UNLOCK_FIRST_REG = 3'h2;
	localparam int TIMEOUT_US = 300;
	localparam int US_PER_S = 1000000;
	localparam int SLOW_HZ_DEFAULT = 32000;

endpackage

// ===== design/unlock_seq.sv
`timescale 1ns/10ps
// Watches the pattern writes of the write-enable procedure against the slow-oscillator timeout
module unlock_seq #(
	parameter int slow_hz = flash_sp_pkg::SLOW_HZ_DEFAULT
) (
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic ce,
	// Procedure control
	input wire logic arm,
	input wire logic slow_tick,
	// Data register writes
	input wire logic data_wr,
	input wire logic [2:0] data_idx,
	input wire logic [7:0] data_byte,
	// Result pulses
	output logic ok_r,
	output logic fail_r
);
	import flash_sp_pkg::*;

	// Timeout is a longest time, so it rounds down, never below one tick
	localparam int TICKS_RAW = TIMEOUT_US * slow_hz / US_PER_S;
	localparam logic [15:0] TIMEOUT_TICKS = (TICKS_RAW < 1) ? 16'h0001 : TICKS_RAW[15:0];

	logic [2:0] step_r;
	logic [15:0] ticks_r;
	logic done_r;

	function automatic logic [7:0] pattern_byte(input logic [2:0] s);
		pattern_byte = UNLOCK_PATTERN[8 * (UNLOCK_LEN - 1 - int'(s)) +: 8];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pattern matcher; one result per arming, then waits for the request to drop
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			step_r <= 3'h0;
			ticks_r <= 16'h0000;
			done_r <= 1'b0;
			ok_r <= 1'b0;
			fail_r <= 1'b0;
		end else if (ce) begin
			ok_r <= 1'b0;
			fail_r <= 1'b0;
			if (!arm) begin
				step_r <= 3'h0;
				ticks_r <= 16'h0000;
				done_r <= 1'b0;
			end else if (!done_r) begin
				if (slow_tick) begin
					ticks_r <= ticks_r + 16'h0001;
				end
				if (slow_tick && ticks_r == TIMEOUT_TICKS - 16'h0001) begin
					fail_r <= 1'b1;
					done_r <= 1'b1;
				end else if (data_wr && data_idx >= UNLOCK_FIRST_REG) begin
					if (data_idx == step_r + UNLOCK_FIRST_REG && data_byte == pattern_byte(step_r)) begin
						if (step_r == 3'(UNLOCK_LEN - 1)) begin
							ok_r <= 1'b1;
							done_r <= 1'b1;
						end
						step_r <= step_r + 3'h1;
					end else begin
						fail_r <= 1'b1;
						done_r <= 1'b1;
					end
				end
			end
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n || !ce);

	timeout_fail_a: assert property (arm && !done_r && slow_tick && ticks_r == TIMEOUT_TICKS - 16'h0001 |=> fail_r && !ok_r)
		else $error("unlock timeout did not fail the attempt");

	// success only after six pattern steps
	ok_after_six_a: assert property (ok_r |-> step_r == 3'(UNLOCK_LEN))
		else $error("unlock success without full pattern");

endmodule

// ===== design/flash_self_programming_ctrl.sv
`timescale 1ns/10ps
// Operation
// - 64-word erase and program, one-word read
// - Write-enabled bit set by hardware only
// - Mode field decodes write, erase, read, unlock
// - Unlock request in unlock mode runs procedure
// - Write start set by software, hardware clears
// - Read permit gates flash reads
// - Read start set by software, hardware clears
// - Writing 55H resets the whole chip
// - Buffer clear set by software, hardware clears
// - Unimplemented bits read as zero
// - Word address from low and high registers
// - First low data write only stores
// - First high write loads buffer, increments address
// - Second and later data pairs are plain storage
// - All registers clear at power-on
// - Timeout or bad pattern leaves writing disabled
// - Good pattern sets write enabled, clears request
// - Processor halted while write or read runs
module flash_self_programming_ctrl #(
	parameter logic large_part = 1'b1,
	parameter int slow_hz = flash_sp_pkg::SLOW_HZ_DEFAULT
) (
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic ce,
	// Special-function register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_sector,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata_r,
	// Slow internal oscillator
	input wire logic slow_osc,
	// Flash array
	output flash_sp_pkg::flash_cmd_e fl_cmd_r,
	output logic fl_req_r,
	output logic [flash_sp_pkg::ADDR_W-1:0] fl_addr_r,
	output logic [15:0] fl_wdata_r,
	input wire logic fl_ack,
	input wire logic [15:0] fl_rdata,
	// System
	output logic cpu_halt_r,
	output logic chip_reset_r
);
	import flash_sp_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_PROG, ST_ERASE, ST_READ, ST_BCLR} op_state_e;

	localparam logic [ADDR_W-1:0] ADDR_MASK = large_part ? MASK_LARGE : MASK_SMALL;

	op_state_e state_r;
	logic [IDX_W-1:0] op_idx_r;
	logic write_enabled_r, unlock_request_r, write_start_r, read_permit_r, read_start_r;
	logic buffer_clear_r;
	mode_t mode_r;
	logic write_enabled_nxt, unlock_request_nxt, write_start_nxt, read_permit_nxt, read_start_nxt;
	logic buffer_clear_nxt;
	mode_t mode_nxt;
	logic [7:0] reset_cmd_r;
	logic [ADDR_W-1:0] addr_r;
	logic [7:0] fd_r [8];
	logic [15:0] wbuf_r [PAGE_WORDS];
	logic slow_meta_r, slow_sync_r, slow_prev_r;
	logic slow_tick;
	logic hit, wr_hit, rd_hit;
	logic go_prog, go_erase, go_read, w_done, w_abort, r_done, r_abort, b_done;
	logic unlock_ok, unlock_fail, unlock_arm;

	////////////////////////////////////////////////////////////////////////
	// Decode helpers shared by the write and read paths
	function automatic logic is_data(input logic [7:0] a);
		is_data = (a >= OFF_DATA_FIRST) && (a <= OFF_DATA_LAST);
	endfunction

	function automatic logic [2:0] data_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - OFF_DATA_FIRST;
		data_idx = d[2:0];
	endfunction

	// Address wraps inside the part's word range
	function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a);
		addr_inc = (a + ADDR_ONE) & ADDR_MASK;
	endfunction

	// registers answer only to the sector one window
	assign hit = (reg_sector == SECTOR_ONE) && (reg_addr >= OFF_CTRL) && (reg_addr <= OFF_DATA_LAST);
	assign wr_hit = reg_wr && hit;
	assign rd_hit = reg_rd && hit;

	////////////////////////////////////////////////////////////////////////
	// Slow oscillator: two flip-flops, then an edge detect on the second
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			slow_meta_r <= 1'b0;
			slow_sync_r <= 1'b0;
			slow_prev_r <= 1'b0;
		end else if (ce) begin
			slow_meta_r <= slow_osc;
			slow_sync_r <= slow_meta_r;
			slow_prev_r <= slow_sync_r;
		end
	end
	assign slow_tick = slow_sync_r & ~slow_prev_r;

	////////////////////////////////////////////////////////////////////////
	// Start decisions and completions
	// write and erase need write enabled
	assign go_prog = write_start_r && write_enabled_r && mode_r == MODE_PROG;
	assign go_erase = write_start_r && write_enabled_r && mode_r == MODE_ERASE;
	// reads gated by the permit bit
	assign go_read = !write_start_r && read_start_r && read_permit_r && mode_r == MODE_READ;
	assign w_abort = state_r == ST_IDLE && write_start_r && !go_prog && !go_erase;
	assign r_abort = state_r == ST_IDLE && !write_start_r && read_start_r && !go_read;
	assign w_done = fl_req_r && fl_ack && (state_r == ST_ERASE || (state_r == ST_PROG && op_idx_r == LAST_IDX));
	assign r_done = fl_req_r && fl_ack && state_r == ST_READ;
	assign b_done = state_r == ST_BCLR && op_idx_r == LAST_IDX;

	// unlock mode code with the request bit arms the procedure
	// request plus mode runs the procedure
	assign unlock_arm = unlock_request_r && mode_r == MODE_UNLOCK;

	////////////////////////////////////////////////////////////////////////
	// Control bits: hardware clears first, software sets after, so a set is never lost
	always_comb begin
		write_enabled_nxt = write_enabled_r;
		mode_nxt = mode_r;
		unlock_request_nxt = unlock_request_r;
		write_start_nxt = write_start_r;
		read_permit_nxt = read_permit_r;
		read_start_nxt = read_start_r;
		buffer_clear_nxt = buffer_clear_r;
		if (w_done || w_abort) begin
			write_start_nxt = 1'b0;
		end
		if (r_done || r_abort) begin
			read_start_nxt = 1'b0;
		end
		// clear bit drops when the buffer is clean
		if (b_done) begin
			buffer_clear_nxt = 1'b0;
		end
		if (unlock_ok || unlock_fail) begin
			unlock_request_nxt = 1'b0;
		end
		if (wr_hit && reg_addr == OFF_CTRL) begin
			// software may only clear write enabled
			if (!reg_wdata[BIT_WEN]) begin
				write_enabled_nxt = 1'b0;
			end
			mode_nxt = reg_wdata[MODE_HI:MODE_LO];
			unlock_request_nxt = reg_wdata[BIT_UNLOCK];
			read_permit_nxt = reg_wdata[BIT_RPERMIT];
			write_start_nxt = write_start_nxt | reg_wdata[BIT_WSTART];
			read_start_nxt = read_start_nxt | reg_wdata[BIT_RSTART];
		end
		if (wr_hit && reg_addr == OFF_BUF_CLEAR) begin
			buffer_clear_nxt = buffer_clear_nxt | reg_wdata[BIT_BCLR];
		end
		// hardware success wins over a software clear
		if (unlock_ok) begin
			write_enabled_nxt = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			write_enabled_r <= 1'b0;
			mode_r <= MODE_PROG;
			unlock_request_r <= 1'b0;
			write_start_r <= 1'b0;
			read_permit_r <= 1'b0;
			read_start_r <= 1'b0;
			buffer_clear_r <= 1'b0;
			cpu_halt_r <= 1'b0;
		end else if (ce) begin
			write_enabled_r <= write_enabled_nxt;
			mode_r <= mode_nxt;
			unlock_request_r <= unlock_request_nxt;
			write_start_r <= write_start_nxt;
			read_permit_r <= read_permit_nxt;
			read_start_r <= read_start_nxt;
			buffer_clear_r <= buffer_clear_nxt;
			cpu_halt_r <= write_start_nxt | read_start_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Chip reset command; the pulse lasts one cycle, the byte stays readable
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			reset_cmd_r <= REG_RESET;
			chip_reset_r <= 1'b0;
		end else if (ce) begin
			chip_reset_r <= 1'b0;
			if (wr_hit && reg_addr == OFF_RESET_CMD) begin
				reset_cmd_r <= reg_wdata;
				chip_reset_r <= reg_wdata == RESET_CMD;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address pair and data registers
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_r <= '0;
			for (int i = 0; i < 8; i++) begin
				fd_r[i] <= REG_RESET;
			end
		end else if (ce) begin
			// low byte and masked high part
			if (wr_hit && reg_addr == OFF_ADDR_LOW) begin
				addr_r[7:0] <= reg_wdata;
			end
			if (wr_hit && reg_addr == OFF_ADDR_HIGH) begin
				addr_r[ADDR_W-1:8] <= reg_wdata[ADDR_W-9:0] & ADDR_MASK[ADDR_W-1:8];
			end
			// first low data write only stores the byte
			// second and later pairs are plain storage
			if (wr_hit && is_data(reg_addr)) begin
				fd_r[data_idx(reg_addr)] <= reg_wdata;
			end
			// first high write steps the address
			if (wr_hit && is_data(reg_addr) && data_idx(reg_addr) == 3'h1) begin
				addr_r <= addr_inc(addr_r);
			end
			// read result lands in the first pair
			if (r_done) begin
				fd_r[0] <= fl_rdata[7:0];
				fd_r[1] <= fl_rdata[15:8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write buffer: one page of words, indexed by the low address bits
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < PAGE_WORDS; i++) begin
				wbuf_r[i] <= 16'h0000;
			end
		end else if (ce) begin
			if (wr_hit && is_data(reg_addr) && data_idx(reg_addr) == 3'h1) begin
				wbuf_r[addr_r[IDX_W-1:0]] <= {reg_wdata, fd_r[0]};
			end
			if (state_r == ST_BCLR) begin
				wbuf_r[op_idx_r] <= 16'h0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Operation sequencer; the array answers each request with one ack
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= ST_IDLE;
			op_idx_r <= IDX_ZERO;
			fl_req_r <= 1'b0;
			fl_cmd_r <= FL_NONE;
			fl_addr_r <= '0;
			fl_wdata_r <= 16'h0000;
		end else if (ce) begin
			unique case (state_r)
				ST_IDLE: begin
					op_idx_r <= IDX_ZERO;
					if (go_prog) begin
						state_r <= ST_PROG;
					end else if (go_erase) begin
						state_r <= ST_ERASE;
					end else if (go_read) begin
						state_r <= ST_READ;
					end else if (buffer_clear_r && !write_start_r && !read_start_r) begin
						state_r <= ST_BCLR;
					end
				end
				ST_PROG, ST_ERASE, ST_READ: begin
					if (!fl_req_r) begin
						fl_req_r <= 1'b1;
						// page program, page erase, single read
						unique case (state_r)
							ST_PROG: begin
								fl_cmd_r <= FL_PROG;
								fl_addr_r <= {addr_r[ADDR_W-1:IDX_W], op_idx_r};
							end
							ST_ERASE: begin
								fl_cmd_r <= FL_ERASE;
								fl_addr_r <= {addr_r[ADDR_W-1:IDX_W], IDX_ZERO};
							end
							default: begin
								fl_cmd_r <= FL_READ;
								fl_addr_r <= addr_r;
							end
						endcase
						fl_wdata_r <= wbuf_r[op_idx_r];
					end else if (fl_ack) begin
						fl_req_r <= 1'b0;
						fl_cmd_r <= FL_NONE;
						op_idx_r <= op_idx_r + 6'h01;
						if (state_r != ST_PROG || op_idx_r == LAST_IDX) begin
							state_r <= ST_IDLE;
						end
					end
				end
				ST_BCLR: begin
					op_idx_r <= op_idx_r + 6'h01;
					if (op_idx_r == LAST_IDX) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register read-back; registered so the data bus sees a flop
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata_r <= REG_RESET;
		end else if (ce) begin
			reg_rdata_r <= REG_RESET;
			if (rd_hit) begin
				if (is_data(reg_addr)) begin
					reg_rdata_r <= fd_r[data_idx(reg_addr)];
				end else if (reg_addr == OFF_CTRL) begin
					reg_rdata_r <= {write_enabled_r, mode_r, unlock_request_r, write_start_r,
						read_permit_r, read_start_r};
				end else if (reg_addr == OFF_RESET_CMD) begin
					reg_rdata_r <= reset_cmd_r;
				end else if (reg_addr == OFF_BUF_CLEAR) begin
					reg_rdata_r <= {BCLR_PAD, buffer_clear_r};
				end else if (reg_addr == OFF_ADDR_LOW) begin
					reg_rdata_r <= addr_r[7:0];
				end else begin
					// unused high address bits read zero
					reg_rdata_r <= {1'b0, addr_r[ADDR_W-1:8]};
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write-enable procedure watcher
	// pattern checked on second to fourth pairs
	unlock_seq #(
		.slow_hz(slow_hz)
	) u_unlock (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.ce(ce),
		.arm(unlock_arm),
		.slow_tick(slow_tick),
		.data_wr(wr_hit && is_data(reg_addr)),
		.data_idx(data_idx(reg_addr)),
		.data_byte(reg_wdata),
		.ok_r(unlock_ok),
		.fail_r(unlock_fail)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n || !ce);

	sequence first_word_data_high_write_s;
		wr_hit && is_data(reg_addr) && data_idx(reg_addr) == 3'h1;
	endsequence

	sequence last_word_s;
		state_r == ST_PROG && fl_req_r && fl_ack && op_idx_r == LAST_IDX;
	endsequence

	wen_by_hw_a: assert property ($rose(write_enabled_r) |-> $past(unlock_ok))
		else $error("write enabled rose without unlock success");

	unlock_good_a: assert property (unlock_ok |=> write_enabled_r && !unlock_request_r)
		else $error("unlock success did not enable writing");

	unlock_bad_a: assert property (unlock_fail && !write_enabled_r |=> !write_enabled_r && !unlock_request_r)
		else $error("unlock failure left request or enable set");

	halt_tracks_a: assert property ((write_start_r || read_start_r) |-> cpu_halt_r)
		else $error("processor not halted during operation");

	locked_ignore_a: assert property (state_r == ST_IDLE && write_start_r && !write_enabled_r
		|=> !write_start_r && state_r == ST_IDLE && !fl_req_r)
		else $error("write or erase started while locked");

	reset_cmd_a: assert property (wr_hit && reg_addr == OFF_RESET_CMD && reg_wdata == RESET_CMD |=> chip_reset_r)
		else $error("reset command did not pulse chip reset");

	addr_step_a: assert property (first_word_data_high_write_s |=> addr_r == addr_inc($past(addr_r)))
		else $error("address did not advance after buffer load");

	page_done_a: assert property (last_word_s |=> state_r == ST_IDLE && !write_start_r && op_idx_r == IDX_ZERO)
		else $error("program burst did not end after last word");

	read_one_a: assert property (r_done |=> fd_r[0] == $past(fl_rdata[7:0]) && !read_start_r && state_r == ST_IDLE)
		else $error("read result not captured in first data pair");

	clear_zero_a: assert property (rd_hit && reg_addr == OFF_BUF_CLEAR |=> reg_rdata_r[7:1] == BCLR_PAD)
		else $error("unimplemented clear bits read non-zero");

	read_gate_a: assert property (state_r == ST_IDLE && read_start_r && !write_start_r && !read_permit_r
		|=> state_r != ST_READ && !read_start_r)
		else $error("read ran without permit");

endmodule

// ===== sim/flash_array_model.sv
`timescale 1ns/10ps
// Behavioural flash array on the far side of the controller
module flash_array_model #(
	parameter int lat = 2
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Request side
	input wire flash_sp_pkg::flash_cmd_e fl_cmd,
	input wire logic fl_req,
	input wire logic [14:0] fl_addr,
	input wire logic [15:0] fl_wdata,
	// Answer side and bench visibility
	output logic fl_ack,
	output logic [15:0] fl_rdata,
	output int acks,
	output logic [14:0] last_addr
);
	import flash_sp_pkg::*;
	logic [15:0] mem [32768];
	int wait_cnt;
	////////////////////////////////////////////////////////////////////////
	// page erase, word access
	// Ack after lat cycles; read data is scrambled outside an ack so stale values never pass
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			fl_ack <= 1'b0;
			wait_cnt <= 0;
			acks <= 0;
			last_addr <= 15'h0000;
			fl_rdata <= 16'hA5A5;
			// Unwritten cells read as erased
			for (int i = 0; i < 32768; i++) begin
				mem[i] = 16'hFFFF;
			end
		end else begin
			fl_ack <= 1'b0;
			fl_rdata <= ~fl_rdata;
			if (fl_req && !fl_ack) begin
				if (wait_cnt < lat) begin
					wait_cnt <= wait_cnt + 1;
				end else begin
					wait_cnt <= 0;
					fl_ack <= 1'b1;
					acks <= acks + 1;
					last_addr <= fl_addr;
					if (fl_cmd == FL_PROG) begin
						mem[fl_addr] = fl_wdata;
					end
					// Erased cells read all ones
					if (fl_cmd == FL_ERASE) begin
						for (int i = 0; i < 64; i++) begin
							mem[{fl_addr[14:6], 6'(i)}] = 16'hFFFF;
						end
					end
					if (fl_cmd == FL_READ) begin
						fl_rdata <= mem[fl_addr];
					end
				end
			end
		end
	end
endmodule

// ===== sim/flash_self_programming_ctrl_tb.sv
`timescale 1ns/10ps
// Register-level bench for the self-programming controller
module flash_self_programming_ctrl_tb;
	import flash_sp_pkg::*;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_sector = SECTOR_ONE;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata_r;
	logic slow_osc = 1'b0;
	flash_cmd_e fl_cmd_r;
	logic fl_req_r, fl_ack, cpu_halt_r, chip_reset_r;
	logic [14:0] fl_addr_r, last_addr;
	logic [15:0] fl_wdata_r, fl_rdata;
	logic [7:0] rv;
	int acks, a0, seen, err_count = 0, checks = 0, cycles = 0;

	// 40 MHz clock; slow oscillator much faster than real so the timeout stays short
	always #12.5 ref_clk = ~ref_clk;
	always #250 slow_osc = ~slow_osc;

	flash_self_programming_ctrl i_flash_self_programming_ctrl (.ref_clk(ref_clk), .arst_n(arst_n),
		.ce(1'b1), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sector(reg_sector), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .slow_osc(slow_osc), .fl_cmd_r(fl_cmd_r),
		.fl_req_r(fl_req_r), .fl_addr_r(fl_addr_r), .fl_wdata_r(fl_wdata_r), .fl_ack(fl_ack),
		.fl_rdata(fl_rdata), .cpu_halt_r(cpu_halt_r), .chip_reset_r(chip_reset_r));
	flash_array_model i_flash_array_model (.ref_clk(ref_clk), .arst_n(arst_n), .fl_cmd(fl_cmd_r),
		.fl_req(fl_req_r), .fl_addr(fl_addr_r), .fl_wdata(fl_wdata_r), .fl_ack(fl_ack),
		.fl_rdata(fl_rdata), .acks(acks), .last_addr(last_addr));

	////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		if (err_count == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Strobe drops and one edge passes, so back-to-back calls never re-assign in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge ref_clk) #1;
		reg_wr = 1'b0;
		@(posedge ref_clk) #1;
	endtask

	task automatic rd(input logic [7:0] a);
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge ref_clk) #1;
		reg_rd = 1'b0;
		rv = reg_rdata_r;
		@(posedge ref_clk) #1;
	endtask

	task automatic wait_idle;
		for (int i = 0; i < 2000 && cpu_halt_r !== 1'b0; i++) @(posedge ref_clk) #1;
		chk(16'(cpu_halt_r), 0);
	endtask

	// Hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge ref_clk);
		#1 arst_n = 1'b1;
		@(posedge ref_clk) #1;
		for (int a = 8'h43; a <= 8'h4F; a++) begin
			rd(8'(a));
			chk(rv, 0);
		end
		rd(8'h50);
		chk(rv, 0);
		reg_sector = 8'h00;
		wr(OFF_CTRL, 8'h33);
		reg_sector = SECTOR_ONE;
		rd(OFF_CTRL);
		chk(rv, 0);
		wr(OFF_ADDR_HIGH, 8'hFF);
		rd(OFF_ADDR_HIGH);
		chk(rv, 8'h7F);
		wr(OFF_BUF_CLEAR, 8'hFF);
		rd(OFF_BUF_CLEAR);
		chk(rv, 8'h01);
		repeat (70) @(posedge ref_clk) #1;
		rd(OFF_BUF_CLEAR);
		chk(rv, 0);
		wr(OFF_CTRL, 8'h80);
		rd(OFF_CTRL);
		chk(rv, 0);
		a0 = acks;
		wr(OFF_CTRL, 8'h04);
		wait_idle();
		rd(OFF_CTRL);
		chk(rv, 0);
		chk(16'(acks - a0), 0);
		// Unlock: timeout, then a wrong byte, then the good pattern
		wr(OFF_CTRL, 8'h68);
		repeat (300) @(posedge ref_clk) #1;
		rd(OFF_CTRL);
		chk(rv, 8'h60);
		wr(OFF_CTRL, 8'h68);
		wr(8'h4A, 8'h01);
		repeat (3) @(posedge ref_clk) #1;
		rd(OFF_CTRL);
		chk(rv, 8'h60);
		wr(OFF_CTRL, 8'h68);
		for (int i = 0; i < UNLOCK_LEN; i++) wr(8'h4A + 8'(i), UNLOCK_PATTERN[47 - 8 * i -: 8]);
		repeat (3) @(posedge ref_clk) #1;
		rd(OFF_CTRL);
		chk(rv, 8'hE0);
		wr(8'h4A, 8'hA5);
		rd(8'h4A);
		chk(rv, 8'hA5);
		// Load one word at the top of page 0; address moves into page 1
		wr(OFF_ADDR_LOW, 8'h3F);
		wr(OFF_ADDR_HIGH, 8'h00);
		wr(8'h48, 8'h34);
		rd(8'h48);
		chk(rv, 8'h34);
		wr(8'h49, 8'h12);
		rd(OFF_ADDR_LOW);
		chk(rv, 8'h40);
		// Low byte alone must not reach the buffer entry of the new address
		wr(8'h48, 8'h77);
		a0 = acks;
		wr(OFF_CTRL, 8'h94);
		wait_idle();
		chk(16'(acks - a0), 1);
		a0 = acks;
		wr(OFF_CTRL, 8'h84);
		@(posedge ref_clk) #1;
		chk(cpu_halt_r, 1);
		wait_idle();
		chk(16'(acks - a0), 64);
		chk(last_addr, 15'h007F);
		rd(OFF_CTRL);
		chk(rv, 8'h80);
		wr(OFF_ADDR_LOW, 8'h7F);
		wr(OFF_CTRL, 8'hB3);
		wait_idle();
		rd(OFF_CTRL);
		chk(rv, 8'hB2);
		rd(8'h48);
		chk(rv, 8'h34);
		rd(8'h49);
		chk(rv, 8'h12);
		// Read start without permit is dropped
		a0 = acks;
		wr(OFF_CTRL, 8'hB1);
		repeat (3) @(posedge ref_clk) #1;
		rd(OFF_CTRL);
		chk(rv, 8'hB0);
		chk(16'(acks - a0), 0);
		// Word at 40H was programmed from a cleared entry
		wr(OFF_ADDR_LOW, 8'h40);
		wr(OFF_CTRL, 8'hB3);
		wait_idle();
		rd(8'h48);
		chk(rv, 8'h00);
		for (int c = 0; c < 8; c++) begin
			if (c == 2 || c == 4 || c == 5 || c == 7) begin
				a0 = acks;
				wr(OFF_CTRL, 8'h84 | 8'(c << 4));
				repeat (3) @(posedge ref_clk) #1;
				rd(OFF_CTRL);
				chk(rv, 8'h80 | 8'(c << 4));
				chk(16'(acks - a0), 0);
			end
		end
		wr(OFF_CTRL, 8'h00);
		rd(OFF_CTRL);
		chk(rv, 0);
		reg_wr = 1'b1;
		reg_addr = OFF_RESET_CMD;
		reg_wdata = RESET_CMD;
		@(posedge ref_clk) #1;
		reg_wr = 1'b0;
		seen = 0;
		repeat (3) begin
			if (chip_reset_r === 1'b1) seen++;
			@(posedge ref_clk) #1;
		end
		chk(16'(seen), 1);
		stop_test();
	end
endmodule
